// ===== hdl/act_transmitter.sv
// Asynchronous character transmitter: bus destination, buffer and serialiser
`timescale 1ns/1ps

module act_transmitter
   import act_pkg::*;
#(
   parameter int BAUD = ACT_BAUD_DEFAULT
) (
   // Clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   // Processor bus
   input  wire act_bus_t   bus_in,
   input  wire logic [7:0] source_bus,
   input  wire logic       sense_not,
   input  wire logic       clear_output_flag,
   input  wire logic       int_ack,
   input  wire logic       int_enable,
   // Processor answers
   output logic            skip_reg,
   output logic            interrupt_status_bit,
   output logic            int_req_reg,
   output logic [7:0]      save_addr_reg,
   output logic [7:0]      vector_addr_reg,
   output logic            transmit_done_flag,
   output logic            buf_ready_reg,
   // Serial line
   output logic            serial_out_reg
);

   // ------------------------------------------------------------
   // Timing derived from clock rate
   // ------------------------------------------------------------
   localparam int TICK_CYC = (ACT_CLK_HZ / (2 * BAUD)) < 1 ? 1 : ACT_CLK_HZ / (2 * BAUD);
   localparam int TW       = $clog2(TICK_CYC + 1);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [TW-1:0] tick_cnt_reg;
   logic          tick;
   logic [7:0]    fifo_data_reg [2];
   logic [1:0]    fifo_cnt_reg;
   logic          fifo_wptr_reg;
   logic          fifo_rptr_reg;
   logic          fifo_in_valid;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic          fifo_out_ready;
   logic [7:0]    fifo_out_data;
   logic [7:0]    shift_reg;
   logic          marker_reg;
   logic          line_reg;
   logic          running_reg;
   logic          div_reg;
   logic          loaded_reg;
   act_stop_t     stop_reg;
   logic          shift_pulse;
   logic          end_detect;
   logic          addr_hit;
   logic          done_set;
   logic          done_clr;

   // Address decode shared by every strobe
   function automatic logic act_hit(input act_bus_t b);
      return b.addr == ACT_DEV_ADDR;
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   assign addr_hit       = act_hit(bus_in);
   assign fifo_in_valid  = bus_in.write & addr_hit;
   assign fifo_in_ready  = fifo_cnt_reg != 2'h2;
   assign fifo_out_valid = fifo_cnt_reg != 2'h0;
   assign fifo_out_data  = fifo_data_reg[fifo_rptr_reg];
   assign fifo_out_ready = !marker_reg && !running_reg && stop_reg == ACT_ST_IDLE && !loaded_reg;
   assign tick           = tick_cnt_reg == TW'(TICK_CYC - 1);
   assign shift_pulse    = tick & running_reg & div_reg;
   assign end_detect     = running_reg && !marker_reg && shift_reg[7:1] == 7'h00;
   assign done_set       = shift_pulse & end_detect & loaded_reg;
   assign done_clr       = (fifo_in_valid & fifo_in_ready)
                         | (bus_in.func_out & addr_hit & clear_output_flag);

   // Free-running half-baud tick
   always_ff @(posedge mclk) begin
      if (!rst_n)
         tick_cnt_reg <= '0;
      else if (clk_en)
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
   end

   // ------------------------------------------------------------
   // Two-entry buffer between bus and serialiser
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fifo_cnt_reg  <= 2'h0;
         fifo_wptr_reg <= 1'b0;
         fifo_rptr_reg <= 1'b0;
      end else if (clk_en) begin
         if (fifo_in_valid && fifo_in_ready) begin
            fifo_data_reg[fifo_wptr_reg] <= source_bus;
            fifo_wptr_reg <= ~fifo_wptr_reg;
         end
         if (fifo_out_valid && fifo_out_ready)
            fifo_rptr_reg <= ~fifo_rptr_reg;
         fifo_cnt_reg <= fifo_cnt_reg + 2'((fifo_in_valid && fifo_in_ready) ? 1 : 0)
                                      - 2'((fifo_out_valid && fifo_out_ready) ? 1 : 0);
      end
   end

   // ------------------------------------------------------------
   // Serialiser: marker, shift register, line stage, running, divider
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shift_reg   <= ACT_SHIFT_RESET;
         marker_reg  <= 1'b0;
         line_reg    <= ACT_MARK;
         running_reg <= 1'b0;
         div_reg     <= 1'b0;
         loaded_reg  <= 1'b0;
      end else if (clk_en) begin
         if (fifo_out_valid && fifo_out_ready) begin
            shift_reg  <= fifo_out_data;
            marker_reg <= 1'b1;
            loaded_reg <= 1'b1;
         end else if (tick && marker_reg && !running_reg && stop_reg == ACT_ST_IDLE) begin
            running_reg <= 1'b1;
            div_reg     <= 1'b0;
         end else if (tick && running_reg) begin
            div_reg <= ~div_reg;
            if (div_reg) begin
               // Marker into bit 7, bit 0 onto the line
               {marker_reg, shift_reg, line_reg} <= {1'b0, marker_reg, shift_reg};
               if (end_detect) begin
                  running_reg <= 1'b0;
                  loaded_reg  <= 1'b0;
               end
            end
         end else if (tick && stop_reg != ACT_ST_IDLE) begin
            // Keep dividing through the stop units, else the sequencer stalls
            div_reg <= ~div_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // Stop unit sequencer: idle line and stop units are MARK
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n)
         stop_reg <= ACT_ST_IDLE;
      else if (clk_en) begin
         case (stop_reg)
            ACT_ST_IDLE:  if (done_set) stop_reg <= ACT_ST_STOP1;
            ACT_ST_STOP1: if (tick && div_reg) stop_reg <= ACT_ST_STOP2;
            ACT_ST_STOP2: if (tick && !div_reg) stop_reg <= ACT_ST_IDLE;
            default:      stop_reg <= ACT_ST_IDLE;
         endcase
      end
   end

   // Line driver: start bit while marker and running, else shifted data or MARK
   always_ff @(posedge mclk) begin
      if (!rst_n)
         serial_out_reg <= ACT_MARK;
      else if (clk_en)
         serial_out_reg <= (marker_reg & running_reg) ? ACT_SPACE
                         : running_reg ? line_reg : ACT_MARK;
   end

   // Stop units are timed by tick pairs of the divider, which keeps
   // toggling until the sequencer returns to idle

   // ------------------------------------------------------------
   // Done flag, sense skip, interrupt
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         transmit_done_flag   <= ACT_DONE_RESET;
         interrupt_status_bit <= 1'b0;
         int_req_reg          <= 1'b0;
         skip_reg             <= 1'b0;
         save_addr_reg        <= ACT_SAVE_ADDR;
         vector_addr_reg      <= ACT_VECTOR_ADDR;
         buf_ready_reg        <= 1'b1;
      end else if (clk_en) begin
         if (done_set)
            transmit_done_flag <= 1'b1;
         else if (done_clr)
            transmit_done_flag <= 1'b0;
         interrupt_status_bit <= done_set ? 1'b1 : done_clr ? 1'b0 : interrupt_status_bit;
         int_req_reg <= (done_set | (transmit_done_flag & ~done_clr)) & int_enable & ~int_ack;
         skip_reg    <= bus_in.sense & addr_hit & (transmit_done_flag ^ sense_not);
         save_addr_reg   <= ACT_SAVE_ADDR;
         vector_addr_reg <= ACT_VECTOR_ADDR;
         buf_ready_reg   <= fifo_cnt_reg == 2'h0 || (fifo_cnt_reg == 2'h1 && !(fifo_in_valid));
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_write;
      fifo_in_valid && fifo_in_ready;
   endsequence

   property p_write_clears;
      @(posedge mclk) disable iff (!rst_n)
      (s_write and clk_en and !done_set) |=> !transmit_done_flag;
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("done flag not cleared by write");

   property p_done_sets;
      @(posedge mclk) disable iff (!rst_n)
      (done_set && clk_en) |=> transmit_done_flag;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("done flag not set at end");

   property p_start_space;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && marker_reg && running_reg) |=> serial_out_reg == ACT_SPACE;
   endproperty
   a_start_space: assert property (p_start_space) else $error("start bit not space");

   property p_idle_mark;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && !running_reg) |=> serial_out_reg == ACT_MARK;
   endproperty
   a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");

   property p_shift_rate;
      @(posedge mclk) disable iff (!rst_n)
      shift_pulse |-> div_reg && tick;
   endproperty
   a_shift_rate: assert property (p_shift_rate) else $error("shift not on divided tick");

   property p_lsb_first;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && shift_pulse) |=> line_reg == $past(shift_reg[0]);
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("bit 0 not sent first");

   property p_stop_two;
      @(posedge mclk) disable iff (!rst_n)
      (stop_reg == ACT_ST_STOP1) |-> !running_reg;
   endproperty
   a_stop_two: assert property (p_stop_two) else $error("frame ran into stop units");

   property p_clear_cmd;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && bus_in.func_out && addr_hit && clear_output_flag && !done_set) |=> !transmit_done_flag;
   endproperty
   a_clear_cmd: assert property (p_clear_cmd) else $error("clear command ignored");

   property p_sense;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && bus_in.sense && addr_hit) |=> skip_reg == ($past(transmit_done_flag) ^ $past(sense_not));
   endproperty
   a_sense: assert property (p_sense) else $error("sense skip wrong");

endmodule

// ===== hdl/act_pkg.sv
// Package: constants and types of the asynchronous character transmitter
package act_pkg;

   // ------------------------------------------------------------
   // Bus addressing and interrupt constants
   // ------------------------------------------------------------
   localparam logic [5:0] ACT_DEV_ADDR      = 6'h3F;   // Device address 77 octal
   localparam logic [7:0] ACT_SAVE_ADDR     = 8'h09;   // Save address 11 octal
   localparam logic [7:0] ACT_VECTOR_ADDR   = 8'h0A;   // Jump address 12 octal
   localparam int         ACT_STATUS_BIT    = 0;       // Interrupt status bit position

   // ------------------------------------------------------------
   // Frame and timing constants
   // ------------------------------------------------------------
   localparam int         ACT_DATA_BITS     = 8;
   localparam int         ACT_CLK_HZ        = 10000000;
   localparam int         ACT_BAUD_DEFAULT  = 9600;
   localparam logic       ACT_MARK          = 1'b1;    // Line idle / logic one
   localparam logic       ACT_SPACE         = 1'b0;
   localparam logic       ACT_DONE_RESET    = 1'b1;    // Done flag after reset
   localparam logic [7:0] ACT_SHIFT_RESET   = 8'h00;

   // ------------------------------------------------------------
   // Stop sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ACT_ST_IDLE  = 2'b00,
      ACT_ST_STOP1 = 2'b01,
      ACT_ST_STOP2 = 2'b10
   } act_stop_t;

   // ------------------------------------------------------------
   // Bus strobe bundle
   // ------------------------------------------------------------
   typedef struct packed {
      logic       write;      // Destination write strobe
      logic       sense;      // Sense-function strobe
      logic       func_out;   // Function-output strobe
      logic [5:0] addr;       // Device address
   } act_bus_t;

endpackage

// ===== sim/act_terminal.sv
// Serial terminal model that decodes frames seen on the transmitter line
`timescale 1ns/1ps

module act_terminal #(
   parameter int BIT_CYC = 10
) (
   // Clock and serial line
   input wire logic mclk,
   input wire logic line_in
);
   logic [7:0] rx_q[$];
   int         frame_errs = 0;
   logic [7:0] shreg;

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   // Samples each unit in its middle, timed from the MARK to SPACE edge
   initial begin
      forever begin
         @(negedge line_in);
         repeat (BIT_CYC / 2) @(posedge mclk);
         if (line_in !== 1'b0) frame_errs++;
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            shreg[i] = line_in;
         end
         repeat (BIT_CYC) @(posedge mclk);
         if (line_in !== 1'b1) frame_errs++;
         repeat (BIT_CYC) @(posedge mclk);
         if (line_in !== 1'b1) frame_errs++;
         rx_q.push_back(shreg);
      end
   end
endmodule

// ===== sim/act_transmitter_tb_top.sv
// Self-checking testbench of the asynchronous character transmitter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); end end

module act_transmitter_tb_top import act_pkg::*;;
   typedef struct packed {logic is_sense; logic [5:0] addr; logic [7:0] val; logic exp;} act_row_t;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic       clk_en = 1'b1;
   act_bus_t   bus_in = '0;
   logic [7:0] source_bus = 8'h00;
   logic       sense_not = 1'b0;
   logic       clear_output_flag = 1'b0;
   logic       int_ack = 1'b0;
   logic       int_enable = 1'b1;
   logic       skip_reg, interrupt_status_bit, int_req_reg, transmit_done_flag, buf_ready_reg, serial_out_reg;
   logic [7:0] save_addr_reg, vector_addr_reg, eb, gb;
   int         fails = 0;
   int         n_tests = 0;
   int         cnt;
   logic [7:0] sent[$];
   act_row_t   rows[9] = '{'{1'b1, 6'h3F, 8'h00, 1'b1}, '{1'b1, 6'h3F, 8'h01, 1'b0}, '{1'b1, 6'h3E, 8'h00, 1'b0},
                           '{1'b0, 6'h3F, 8'h55, 1'b0}, '{1'b0, 6'h3F, 8'hA3, 1'b0}, '{1'b0, 6'h3F, 8'h00, 1'b0},
                           '{1'b0, 6'h3F, 8'hFF, 1'b0}, '{1'b0, 6'h3F, 8'h80, 1'b0}, '{1'b0, 6'h3F, 8'h01, 1'b0}};

   // Half period of 50 ns gives 10 MHz
   always #50 mclk = ~mclk;

   act_transmitter #(.BAUD(1000000)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .bus_in(bus_in), .source_bus(source_bus),
      .sense_not(sense_not), .clear_output_flag(clear_output_flag), .int_ack(int_ack),
      .int_enable(int_enable), .skip_reg(skip_reg), .interrupt_status_bit(interrupt_status_bit),
      .int_req_reg(int_req_reg), .save_addr_reg(save_addr_reg), .vector_addr_reg(vector_addr_reg),
      .transmit_done_flag(transmit_done_flag), .buf_ready_reg(buf_ready_reg), .serial_out_reg(serial_out_reg));

   act_terminal #(.BIT_CYC(10)) u_term (.mclk(mclk), .line_in(serial_out_reg));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic summarize;
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One-cycle strobe, held until the sampling edge, then released
   task automatic bus_op(input logic w, s, f, input logic [5:0] a, input logic [7:0] d, input logic sn, clr);
      @(posedge mclk);
      bus_in <= '{write: w, sense: s, func_out: f, addr: a};
      source_bus <= d;
      sense_not <= sn;
      clear_output_flag <= clr;
      @(posedge mclk);
      bus_in <= '0;
      #1;
   endtask

   // Bounded wait for the done flag (sel 0) or the line (sel 1) to reach lvl
   task automatic wait_for(input int sel, input logic lvl);
      cnt = 0;
      while ((sel == 1 ? serial_out_reg : transmit_done_flag) !== lvl) begin
         @(posedge mclk);
         #1;
         cnt++;
         if (cnt > 3000) begin
            fails++;
            summarize();
         end
      end
   endtask

   // Every sent byte must arrive, in order
   task automatic check_rx;
      for (int t = 0; u_term.rx_q.size() < sent.size(); t++) begin
         @(posedge mclk);
         if (t > 6000) begin
            fails++;
            summarize();
         end
      end
      while (sent.size() > 0) begin
         eb = sent.pop_front();
         gb = u_term.rx_q.pop_front();
         `CHK("rx_byte", eb, gb)
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      #1;
      `CHK("done_rst", 1'b1, transmit_done_flag)
      `CHK("isb_rst", 1'b0, interrupt_status_bit)
      `CHK("line_rst", ACT_MARK, serial_out_reg)
      `CHK("save_addr", 8'h09, save_addr_reg)
      `CHK("vector_addr", 8'h0A, vector_addr_reg)
      @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("int_req", 1'b1, int_req_reg)
      @(posedge mclk);
      int_ack <= 1'b1;
      @(posedge mclk);
      #1;
      `CHK("int_ack", 1'b0, int_req_reg)
      int_ack <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].is_sense) begin
            bus_op(1'b0, 1'b1, 1'b0, rows[i].addr, 8'h00, rows[i].val[0], 1'b0);
            `CHK("skip", rows[i].exp, skip_reg)
         end else begin
            bus_op(1'b1, 1'b0, 1'b0, rows[i].addr, rows[i].val, 1'b0, 1'b0);
            `CHK("done_clr", 1'b0, transmit_done_flag)
            sent.push_back(rows[i].val);
            wait_for(0, 1'b1);
            check_rx();
         end
      end
      // Busy sense, then the moment the flag sets within the frame
      bus_op(1'b1, 1'b0, 1'b0, 6'h3F, 8'h96, 1'b0, 1'b0);
      sent.push_back(8'h96);
      bus_op(1'b0, 1'b1, 1'b0, 6'h3F, 8'h00, 1'b1, 1'b0);
      `CHK("skip_busy", 1'b1, skip_reg)
      `CHK("int_busy", 1'b0, int_req_reg)
      `CHK("isb_busy", 1'b0, interrupt_status_bit)
      wait_for(1, 1'b0);
      wait_for(0, 1'b1);
      `CHK("done_time", 1'b1, (cnt >= 77 && cnt <= 90))
      `CHK("isb_done", 1'b1, interrupt_status_bit)
      check_rx();
      `CHK("line_idle", ACT_MARK, serial_out_reg)
      // Foreign address, then the clear command
      bus_op(1'b1, 1'b0, 1'b0, 6'h3E, 8'h12, 1'b0, 1'b0);
      `CHK("wrong_addr", 1'b1, transmit_done_flag)
      bus_op(1'b0, 1'b0, 1'b1, 6'h3F, 8'h00, 1'b0, 1'b1);
      `CHK("clear_output_flag", 1'b0, transmit_done_flag)
      `CHK("isb_clear_output_flag", 1'b0, interrupt_status_bit)
      repeat (2) @(posedge mclk);
      #1;
      `CHK("clear_output_flag_int", 1'b0, int_req_reg)
      repeat (150) @(posedge mclk);
      `CHK("clear_output_flag_line", ACT_MARK, serial_out_reg)
      `CHK("no_frame", 0, u_term.rx_q.size())
      // Fill the buffer, drop one write, drain with two stop units between
      for (int k = 0; k < 5 && buf_ready_reg === 1'b1; k++) begin
         bus_op(1'b1, 1'b0, 1'b0, 6'h3F, 8'hC0 + 8'(k), 1'b0, 1'b0);
         sent.push_back(8'hC0 + 8'(k));
      end
      `CHK("buf_full", 1'b0, buf_ready_reg)
      bus_op(1'b1, 1'b0, 1'b0, 6'h3F, 8'h77, 1'b0, 1'b0);
      check_rx();
      wait_for(0, 1'b1);
      repeat (200) @(posedge mclk);
      #1;
      `CHK("dropped", 0, u_term.rx_q.size())
      `CHK("buf_empty", 1'b1, buf_ready_reg)
      `CHK("frame_errs", 0, u_term.frame_errs)
      `CHK("int_end", 1'b1, int_req_reg)
      @(posedge mclk);
      int_enable <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("int_off", 1'b0, int_req_reg)
      summarize();
   end
endmodule
